// *** hw/rfc_pkg.sv ***
package rfc_pkg;
  // Frame framing bytes.
  localparam logic [7:0] SOH_BYTE = 8'h01;
  // Transponder type codes carried in the low status bits.
  localparam logic [1:0] TYPE_READ_ONLY = 2'h0;
  localparam logic [1:0] TYPE_RW = 2'h1;
  localparam logic [1:0] TYPE_MULTIPAGE = 2'h2;
  localparam logic [1:0] TYPE_OTHER = 2'h3;
  // Read address layout: page in the upper six bits, status in the lower two.
  localparam int RA_PAGE_LSB = 2;
  localparam int RA_PAGE_W = 6;
  localparam int RA_STAT_W = 2;
  localparam logic [1:0] RA_UNLOCKED = 2'h0;
  localparam logic [1:0] RA_PROG_DONE = 2'h1;
  localparam logic [1:0] RA_LOCKED = 2'h2;
  localparam logic [1:0] RA_RESERVED = 2'h3;
  localparam logic [5:0] RA_PAGE_NONE = 6'h00;
  // Multipage reply carries eight identification bytes and the read address.
  localparam logic [7:0] MULTIPAGE_DATA_LEN = 8'h09;
  localparam int ID_BYTES = 8;
  // Programming frame constants for the 64-bit read/write transponder.
  localparam logic [7:0] RW_KEYWORD = 8'hbb;
  localparam logic [7:0] RW_PASSWORD = 8'heb;
  localparam logic [15:0] RW_FRAME_CODE = 16'h0300;
  // Timing in the documented units and the clock rate.
  localparam longint CLK_HZ = 40000000;
  localparam longint INTERBYTE_MS = 10;
  localparam longint CYC_NOSYNC_NOREAD_MS = 105;
  localparam longint CYC_NOSYNC_READ_MS = 175;
  localparam longint CYC_SYNC_NOREAD_MS = 175;
  localparam longint CYC_SYNC_READ_MS = 245;
  // Cycle counts; longest times round down.
  localparam longint INTERBYTE_CYC = INTERBYTE_MS * CLK_HZ / 1000;
  localparam longint NOSYNC_NOREAD_CYC = CYC_NOSYNC_NOREAD_MS * CLK_HZ / 1000;
  localparam longint NOSYNC_READ_CYC = CYC_NOSYNC_READ_MS * CLK_HZ / 1000;
  localparam longint SYNC_NOREAD_CYC = CYC_SYNC_NOREAD_MS * CLK_HZ / 1000;
  localparam longint SYNC_READ_CYC = CYC_SYNC_READ_MS * CLK_HZ / 1000;
  // Receive parser states.
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_LEN = 3'b001,
    RX_BODY = 3'b010,
    RX_CHECK = 3'b011
  } rfc_rx_state_type;
endpackage

// *** hw/rfc_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module rfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("rfc_fifo depth must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  // Full and empty come from pointers with one extra wrap bit.
  assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q[AW-1:0]];

  // Storage is written without reset; only pointers carry control state.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointer updates.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + (AW+1)'(1);
      end
      if (pop) begin
        rd_q <= rd_q + (AW+1)'(1);
      end
    end
  end

  a_fifo_no_overflow: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_q - rd_q) <= (AW+1)'(DEPTH))
    else $error("fifo occupancy exceeds depth");
endmodule
`default_nettype wire

// *** hw/rfc_addr_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module rfc_addr_decode (
  input wire logic [7:0] read_addr,
  output logic [5:0] page,
  output logic [1:0] status,
  output logic unlocked_read,
  output logic prog_done,
  output logic locked_read,
  output logic reserved,
  output logic unreliable
);
  // Split the read address into its page and status fields.
  always_comb begin
    page = read_addr[rfc_pkg::RA_PAGE_LSB +: rfc_pkg::RA_PAGE_W]; // see R7 R9
    status = read_addr[rfc_pkg::RA_STAT_W-1:0]; // see R7
    unlocked_read = status == rfc_pkg::RA_UNLOCKED; // see R8
    prog_done = status == rfc_pkg::RA_PROG_DONE; // see R8
    locked_read = status == rfc_pkg::RA_LOCKED; // see R8
    reserved = status == rfc_pkg::RA_RESERVED; // see R8
    // A zero page flags doubt; reserved status is not a real outcome at all.
    unreliable = (page == rfc_pkg::RA_PAGE_NONE) && !reserved; // see R10
  end
endmodule
`default_nettype wire

// *** hw/rfc_frame_check.sv ***
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: Last frame byte is XOR of all prior bytes except start byte.
// R2: Inter-byte gap reaching about 10 ms resets the reader.
// R3: Unsynchronised read cycle ends within 105 ms no read, 175 ms read.
// R4: Synchronised read cycle ends within 175 ms no read, 245 ms read.
// R5: Read/write programming frame carries keyword BB, password EB, code 0300.
// R6: Host sends a write-address byte choosing function and page.
// R7: Read address is six-bit page above two-bit status.
// R8: Status 00 unlocked read, 01 programmed, 10 locked read, 11 reserved.
// R9: Page field is the page number in plain binary.
// R10: Zero page means outcome unreliable, kind given by status.
// R11: Reserved status means data is not identification data.
// R12: Host should check read address after each multipage command.
// R13: Host repeats a command reported as unreliable.
// R14: Frames start with 01 which is excluded from the check.
// R15: Reply length counts status and data bytes, not check byte.
// R16: Multipage reply holds eight ID bytes low first, then read address.
// R17: Time-out discards partial frame and waits for a new start byte.
module rfc_frame_check #(
  parameter longint INTERBYTE_CYC = rfc_pkg::INTERBYTE_CYC,
  parameter longint NOSYNC_NOREAD_CYC = rfc_pkg::NOSYNC_NOREAD_CYC,
  parameter longint NOSYNC_READ_CYC = rfc_pkg::NOSYNC_READ_CYC,
  parameter longint SYNC_NOREAD_CYC = rfc_pkg::SYNC_NOREAD_CYC,
  parameter longint SYNC_READ_CYC = rfc_pkg::SYNC_READ_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_frame_ok,
  output logic rx_frame_bad,
  output logic rx_timeout,
  output logic reader_reset,
  input wire logic cycle_start,
  input wire logic cycle_sync,
  input wire logic cycle_valid_read,
  output logic cycle_done,
  input wire logic rsp_valid,
  output logic rsp_ready,
  input wire logic [7:0] rsp_status,
  input wire logic [63:0] rsp_id,
  input wire logic [7:0] rsp_read_addr,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic [5:0] ra_page,
  output logic [1:0] ra_status,
  output logic ra_unreliable,
  output logic ra_reserved
);
  localparam int TW = 24;

  initial begin
    if (INTERBYTE_CYC < 1 || NOSYNC_NOREAD_CYC < 1 || SYNC_READ_CYC >= (64'd1 << TW)) begin
      $error("rfc_frame_check timing counts out of range");
    end
  end

  rfc_pkg::rfc_rx_state_type rx_st_q;
  logic [7:0] rx_len_q;
  logic [7:0] rx_xor_q;
  logic [TW-1:0] gap_q;
  logic gap_hit;

  // Inter-byte gap counter runs only while a frame is partly received.
  assign gap_hit = (rx_st_q != rfc_pkg::RX_IDLE) && !rx_valid &&
                   (gap_q == TW'(INTERBYTE_CYC - 1));

  always_ff @(posedge clk) begin
    if (sys_rst || rx_st_q == rfc_pkg::RX_IDLE || rx_valid) begin
      gap_q <= '0;
    end else begin
      gap_q <= gap_q + TW'(1); // see R2
    end
  end

  // Receive parser: start byte, length, body, check byte.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_st_q <= rfc_pkg::RX_IDLE;
      rx_len_q <= '0;
      rx_xor_q <= '0;
    end else if (gap_hit) begin
      rx_st_q <= rfc_pkg::RX_IDLE; // see R17
    end else if (rx_valid) begin
      unique case (rx_st_q)
        rfc_pkg::RX_IDLE: begin
          if (rx_data == rfc_pkg::SOH_BYTE) begin
            rx_st_q <= rfc_pkg::RX_LEN;
            rx_xor_q <= '0; // see R14
          end
        end
        rfc_pkg::RX_LEN: begin
          rx_len_q <= rx_data;
          rx_xor_q <= rx_data; // see R1
          rx_st_q <= (rx_data == 8'h00) ? rfc_pkg::RX_CHECK : rfc_pkg::RX_BODY;
        end
        rfc_pkg::RX_BODY: begin
          rx_xor_q <= rx_xor_q ^ rx_data; // see R1
          rx_len_q <= rx_len_q - 8'h01;
          if (rx_len_q == 8'h01) begin
            rx_st_q <= rfc_pkg::RX_CHECK;
          end
        end
        rfc_pkg::RX_CHECK: begin
          rx_st_q <= rfc_pkg::RX_IDLE;
        end
        default: begin
          rx_st_q <= rfc_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Frame verdict pulses and the reset request on time-out.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_frame_ok <= 1'b0;
      rx_frame_bad <= 1'b0;
      rx_timeout <= 1'b0;
      reader_reset <= 1'b0;
    end else begin
      rx_frame_ok <= rx_valid && !gap_hit && rx_st_q == rfc_pkg::RX_CHECK &&
                     rx_data == rx_xor_q; // see R1
      rx_frame_bad <= rx_valid && !gap_hit && rx_st_q == rfc_pkg::RX_CHECK &&
                      rx_data != rx_xor_q;
      rx_timeout <= gap_hit; // see R2
      reader_reset <= gap_hit; // see R2
    end
  end

  // Read cycle timer; the limit depends on sync and on the read outcome.
  logic [TW-1:0] cyc_q;
  logic cyc_busy_q;
  logic [TW-1:0] cyc_limit;

  always_comb begin
    if (cycle_sync) begin
      cyc_limit = cycle_valid_read ? TW'(SYNC_READ_CYC) : TW'(SYNC_NOREAD_CYC); // see R4
    end else begin
      cyc_limit = cycle_valid_read ? TW'(NOSYNC_READ_CYC) : TW'(NOSYNC_NOREAD_CYC); // see R3
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || gap_hit) begin
      cyc_busy_q <= 1'b0;
      cyc_q <= '0;
      cycle_done <= 1'b0;
    end else begin
      cycle_done <= 1'b0;
      if (!cyc_busy_q && cycle_start) begin
        cyc_busy_q <= 1'b1;
        cyc_q <= TW'(1);
      end else if (cyc_busy_q) begin
        // The cycle is closed at the longest allowed time at the latest.
        if (cyc_q >= cyc_limit) begin
          cyc_busy_q <= 1'b0;
          cycle_done <= 1'b1; // see R3 R4
        end else begin
          cyc_q <= cyc_q + TW'(1);
        end
      end
    end
  end

  // Read address decode for multipage replies.
  logic [5:0] dec_page;
  logic [1:0] dec_stat;
  logic dec_unrel;
  logic dec_res;

  rfc_addr_decode u_dec (
    .read_addr(rsp_read_addr),
    .page(dec_page),
    .status(dec_stat),
    .unlocked_read(),
    .prog_done(),
    .locked_read(),
    .reserved(dec_res),
    .unreliable(dec_unrel)
  );

  // Reply serializer: start, length, status, data, check byte into FIFO.
  logic [3:0] tx_idx_q;
  logic tx_busy_q;
  logic [7:0] tx_len_q;
  logic [7:0] tx_xor_q;
  logic [7:0] tx_st_q;
  logic [71:0] tx_body_q;
  logic [7:0] f_data;
  logic f_valid;
  logic f_ready;
  logic is_multipage;

  assign is_multipage = rsp_status[1:0] == rfc_pkg::TYPE_MULTIPAGE;

  always_comb begin
    f_valid = tx_busy_q;
    if (tx_idx_q == 4'h0) begin
      f_data = rfc_pkg::SOH_BYTE; // see R14
    end else if (tx_idx_q == 4'h1) begin
      f_data = tx_len_q; // see R15
    end else if (tx_idx_q == 4'h2) begin
      f_data = tx_st_q;
    end else if (tx_idx_q == 4'(tx_len_q + 8'h02)) begin
      f_data = tx_xor_q; // see R1
    end else begin
      f_data = tx_body_q[7:0]; // see R16
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_busy_q <= 1'b0;
      rsp_ready <= 1'b1;
      tx_idx_q <= '0;
      tx_len_q <= '0;
      tx_xor_q <= '0;
      tx_st_q <= '0;
      tx_body_q <= '0;
    end else if (!tx_busy_q) begin
      if (rsp_valid) begin
        tx_busy_q <= 1'b1;
        // Ready is kept in its own flop as the inverse of busy, so the port has no gate.
        rsp_ready <= 1'b0;
        tx_idx_q <= '0;
        tx_st_q <= rsp_status;
        tx_body_q <= {rsp_read_addr, rsp_id}; // see R16
        // The length covers the status byte as well as the data bytes.
        tx_len_q <= is_multipage ? rfc_pkg::MULTIPAGE_DATA_LEN + 8'h01 :
                    8'(rfc_pkg::ID_BYTES + 1); // see R15
        tx_xor_q <= '0;
      end
    end else if (f_ready) begin
      // Back-pressure from the FIFO holds the serializer in place.
      tx_idx_q <= tx_idx_q + 4'h1;
      if (tx_idx_q != 4'h0) begin
        tx_xor_q <= tx_xor_q ^ f_data; // see R1 R14
      end
      if (tx_idx_q > 4'h2) begin
        tx_body_q <= {8'h00, tx_body_q[71:8]};
      end
      if (tx_idx_q == 4'(tx_len_q + 8'h02)) begin
        tx_busy_q <= 1'b0;
        rsp_ready <= 1'b1;
      end
    end
  end

  // Latched decode of the last multipage reply's read address.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ra_page <= '0;
      ra_status <= '0;
      ra_unreliable <= 1'b0;
      ra_reserved <= 1'b0;
    end else if (rsp_valid && !tx_busy_q && is_multipage) begin
      ra_page <= dec_page; // see R9
      ra_status <= dec_stat; // see R8
      ra_unreliable <= dec_unrel; // see R10
      ra_reserved <= dec_res; // see R8
    end
  end

  logic [7:0] q_data;
  logic q_valid;

  rfc_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(f_valid),
    .in_ready(f_ready),
    .in_data(f_data),
    .out_valid(q_valid),
    .out_ready(!tx_valid || tx_ready),
    .out_data(q_data)
  );

  // Output stage register so the link sees flip-flop outputs.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_valid <= 1'b0;
      tx_data <= '0;
    end else if (!tx_valid || tx_ready) begin
      tx_valid <= q_valid;
      tx_data <= q_data;
    end
  end

  a_timeout_reset: assert property (@(posedge clk) disable iff (sys_rst)
    gap_hit |=> reader_reset && rx_st_q == rfc_pkg::RX_IDLE) // see R2 R17
    else $error("time-out did not reset the parser");
  a_good_check: assert property (@(posedge clk) disable iff (sys_rst)
    rx_valid && rx_st_q == rfc_pkg::RX_CHECK && rx_data == rx_xor_q && !gap_hit
    |=> rx_frame_ok && !rx_frame_bad) // see R1
    else $error("matching check byte not accepted");
  a_cycle_bound: assert property (@(posedge clk) disable iff (sys_rst)
    cyc_busy_q |-> cyc_q <= TW'(SYNC_READ_CYC)) // see R3 R4
    else $error("read cycle ran past its limit");
  a_multipage_length: assert property (@(posedge clk) disable iff (sys_rst)
    rsp_valid && !tx_busy_q && is_multipage |=>
    tx_len_q == rfc_pkg::MULTIPAGE_DATA_LEN + 8'h01) // see R16 R15
    else $error("multipage reply length wrong");
  a_start_byte: assert property (@(posedge clk) disable iff (sys_rst)
    tx_busy_q && tx_idx_q == 4'h0 |-> f_data == rfc_pkg::SOH_BYTE) // see R14
    else $error("reply does not open with start byte");
  a_page_decode: assert property (@(posedge clk) disable iff (sys_rst)
    rsp_valid && !tx_busy_q && is_multipage |=> ra_page == $past(rsp_read_addr[7:2])) // see R7 R9
    else $error("page field decoded wrongly");
  a_unrel_decode: assert property (@(posedge clk) disable iff (sys_rst)
    rsp_valid && !tx_busy_q && is_multipage && rsp_read_addr[7:2] == 6'h00 &&
    rsp_read_addr[1:0] != 2'h3 |=> ra_unreliable) // see R10
    else $error("zero page not flagged unreliable");
  a_status_decode: assert property (@(posedge clk) disable iff (sys_rst)
    rsp_valid && !tx_busy_q && is_multipage |=> ra_status == $past(rsp_read_addr[1:0]) &&
    ra_reserved == ($past(rsp_read_addr[1:0]) == 2'h3)) // see R8
    else $error("status field decoded wrongly");
endmodule
`default_nettype wire

// *** tb/rfc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rfc_host_model (
  input wire logic clk,
  input wire logic stall,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data
);
  logic [7:0] got[$];

  // Line idles with no byte offered.
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end

  // A stalled host takes nothing, so the reply buffer has to hold the bytes.
  assign tx_ready = !stall;

  // Reply bytes are kept in arrival order.
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready) begin
      got.push_back(tx_data);
    end
  end

  // One pulse per byte; between bytes the line shows the inverse so stale data never matches.
  task automatic send_byte(input logic [7:0] b);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask

  // Start byte, length, payload and check byte; a corrupt frame inverts the check.
  task automatic send_frame(input logic [7:0] p [0:7], input int n, input bit bad);
    logic [7:0] x;
    x = n[7:0];
    send_byte(rfc_pkg::SOH_BYTE);
    send_byte(n[7:0]);
    for (int i = 0; i < n; i++) begin
      send_byte(p[i]);
      x = x ^ p[i];
    end
    send_byte(bad ? ~x : x);
  endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam longint IB = 50;
  logic clk, sys_rst, stall, rx_valid, rx_frame_ok, rx_frame_bad, rx_timeout, reader_reset;
  logic cycle_start, cycle_sync, cycle_valid_read, cycle_done, rsp_valid, rsp_ready;
  logic tx_valid, tx_ready, ra_unreliable, ra_reserved;
  logic [7:0] rx_data, rsp_status, rsp_read_addr, tx_data;
  logic [63:0] rsp_id;
  logic [5:0] ra_page;
  logic [1:0] ra_status;
  int n_mismatch, n_checks, n_ok, n_bad, n_to, n_rr, n_done;
  longint cyc, to_at, done_at;
  logic [7:0] ra_tab [0:5] = '{8'h09, 8'h44, 8'h02, 8'h01, 8'h07, 8'h03};

  rfc_frame_check #(.INTERBYTE_CYC(IB), .NOSYNC_NOREAD_CYC(100), .NOSYNC_READ_CYC(200),
    .SYNC_NOREAD_CYC(200), .SYNC_READ_CYC(300)) DUT (.clk(clk), .sys_rst(sys_rst),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_frame_ok(rx_frame_ok),
    .rx_frame_bad(rx_frame_bad), .rx_timeout(rx_timeout), .reader_reset(reader_reset),
    .cycle_start(cycle_start), .cycle_sync(cycle_sync), .cycle_valid_read(cycle_valid_read),
    .cycle_done(cycle_done), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_status(rsp_status), .rsp_id(rsp_id), .rsp_read_addr(rsp_read_addr),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .ra_page(ra_page),
    .ra_status(ra_status), .ra_unreliable(ra_unreliable), .ra_reserved(ra_reserved));

  rfc_host_model host (.clk(clk), .stall(stall), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));

  // Free-running clock at 40 MHz.
  always #12.5 clk = ~clk;

  // Pulses are counted per edge, so a pulse that stands too long counts twice.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rx_frame_ok === 1'b1) n_ok <= n_ok + 1;
    if (rx_frame_bad === 1'b1) n_bad <= n_bad + 1;
    if (reader_reset === 1'b1) n_rr <= n_rr + 1;
    if (rx_timeout === 1'b1) begin
      n_to <= n_to + 1;
      to_at <= cyc;
    end
    if (cycle_done === 1'b1) begin
      n_done <= n_done + 1;
      done_at <= cyc;
    end
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Stray idle byte, good and corrupt frames, programming and page-read frames.
  task automatic t_frames;
    logic [7:0] p [0:7];
    int k0, b0;
    p = '{8'h08, 8'h32, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    k0 = n_ok;
    b0 = n_bad;
    host.send_byte(8'h38);
    host.send_frame(p, 2, 1'b0);
    host.send_frame(p, 2, 1'b1);
    p = '{8'h48, 8'hbb, 8'heb, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
    host.send_frame(p, 5, 1'b0);
    p = '{8'h48, 8'h32, 8'h01, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
    host.send_frame(p, 4, 1'b0);
    repeat (3) @(negedge clk);
    chk("frame_ok_count", n_ok - k0, 3);
    chk("frame_bad_count", n_bad - b0, 1);
  endtask

  // A partial frame left idle must time out once and be discarded.
  task automatic t_timeout;
    logic [7:0] p [0:7];
    int k0, r0, o0, b0;
    longint t0;
    p = '{8'h48, 8'h32, 8'h01, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
    k0 = n_to;
    r0 = n_rr;
    host.send_byte(8'h01);
    host.send_byte(8'h04);
    host.send_byte(8'h48);
    @(negedge clk);
    t0 = cyc;
    repeat (IB + 20) @(negedge clk);
    chk("timeout_count", n_to - k0, 1);
    chk("reset_count", n_rr - r0, 1);
    chk("timeout_gap", (to_at - t0 >= IB - 3) && (to_at - t0 <= IB + 3), 1);
    o0 = n_ok;
    b0 = n_bad;
    host.send_frame(p, 4, 1'b0);
    repeat (3) @(negedge clk);
    chk("after_timeout_ok", n_ok - o0, 1);
    chk("after_timeout_bad", n_bad - b0, 0);
  endtask

  // A read cycle ends at its limit; a second start while busy is ignored.
  task automatic t_cycle(input logic s, input logic v, input longint lim);
    int d0;
    longint t0;
    @(posedge clk);
    cycle_sync <= s;
    cycle_valid_read <= v;
    cycle_start <= 1'b1;
    @(posedge clk);
    cycle_start <= 1'b0;
    @(negedge clk);
    t0 = cyc;
    d0 = n_done;
    // A second start while busy must neither restart nor stretch the cycle.
    repeat (10) @(posedge clk);
    cycle_start <= 1'b1;
    @(posedge clk);
    cycle_start <= 1'b0;
    for (int i = 0; i < 500 && n_done == d0; i++) @(negedge clk);
    chk("cycle_done_count", n_done - d0, 1);
    chk("cycle_length", (done_at - t0 >= lim - 3) && (done_at - t0 <= lim + 2), 1);
  endtask

  // One reply, optionally with the host stalled so the buffer fills.
  // Only a multipage reply carries the read address and updates the decode.
  task automatic t_reply(input logic [7:0] ra, input logic [7:0] sts, input int st);
    logic [7:0] e [0:12];
    logic [63:0] id;
    logic mp;
    int n;
    logic [5:0] pg0;
    logic [1:0] st0;
    logic un0, rs0;
    id = {40'h0000000000, 8'h2d, 8'hc6, ra};
    mp = sts[1:0] == rfc_pkg::TYPE_MULTIPAGE;
    n = mp ? 13 : 12;
    pg0 = ra_page;
    st0 = ra_status;
    un0 = ra_unreliable;
    rs0 = ra_reserved;
    host.got.delete();
    for (int i = 0; i < 200 && rsp_ready !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
    rsp_valid <= 1'b1;
    rsp_status <= sts;
    rsp_id <= id;
    rsp_read_addr <= ra;
    stall <= (st > 0);
    @(negedge clk);
    for (int i = 0; i < 200 && rsp_ready !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
    rsp_valid <= 1'b0;
    repeat (st) @(posedge clk);
    stall <= 1'b0;
    for (int i = 0; i < 300 && host.got.size() < n; i++) @(negedge clk);
    e[0] = 8'h01;
    e[1] = mp ? 8'h0a : 8'h09;
    e[2] = sts;
    for (int k = 0; k < 8; k++) e[3 + k] = id[8 * k +: 8];
    e[11] = ra;
    e[n - 1] = 8'h00;
    for (int k = 1; k < n - 1; k++) e[n - 1] = e[n - 1] ^ e[k];
    repeat (4) @(negedge clk);
    chk("reply_size", host.got.size(), n);
    for (int k = 0; k < n && k < host.got.size(); k++) chk("reply_byte", host.got[k], e[k]);
    chk("ra_page", ra_page, mp ? ra[7:2] : pg0);
    chk("ra_status", ra_status, mp ? ra[1:0] : st0);
    chk("ra_unreliable", ra_unreliable, mp ? (ra[7:2] == 6'h00 && ra[1:0] != 2'h3) : un0);
    chk("ra_reserved", ra_reserved, mp ? (ra[1:0] == 2'h3) : rs0);
  endtask

  // Reset, then every scenario in turn; t_reply checks each read address that comes back.
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    stall = 1'b0;
    cycle_start = 1'b0;
    cycle_sync = 1'b0;
    cycle_valid_read = 1'b0;
    rsp_valid = 1'b0;
    rsp_status = 8'h00;
    rsp_id = 64'h0;
    rsp_read_addr = 8'h00;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_frames;
    t_timeout;
    t_cycle(1'b0, 1'b0, 100);
    t_cycle(1'b0, 1'b1, 200);
    t_cycle(1'b1, 1'b0, 200);
    t_cycle(1'b1, 1'b1, 300);
    for (int i = 0; i < 6; i++) t_reply(ra_tab[i], 8'h1e, (i == 0) ? 60 : 0);
    t_reply(8'h02, 8'h1e, 0);
    t_reply(8'h45, 8'h0d, 0);
    t_reply(8'h44, 8'he1, 0);
    stop_test;
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    stop_test;
  end
endmodule
`default_nettype wire
